/* logic/sac_adc_ctrl.sv */
// Notes on behaviour
// - a 12-bit result is found by successive approximation of the chosen input.
// - converter clock is system clock divided by 256 down to 2 by select.
// - writing 1 to control bit 3 starts a conversion.
// - hardware clears the start bit at conversion end; reads 1 while busy.
// - 5-bit channel code 0 to 12 picks external inputs; others reserved.
// - code 01110 picks the bandgap, code 10111 a quarter of supply.
// - 2-bit reference field: 00 low choice, 01 2.48 V, 11 2.00 V.
// - with field 00, select bit 0 means supply, 1 means 1.2 V bandgap.
// - result bits 11..4 in their own register, bits 3..0 in control upper nibble.
// - conversion end sets bit 7 of the interrupt flag register.
// - flag bits written 0 clear, bits written 1 are left alone.
//
// Local design decision: register access over AXI4-Lite.
`include "sac_consts.svh"

module sac_adc_ctrl
   import sac_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int WIDTH  = 12
) (
   input  wire logic              mclk,
   input  wire logic              arst_n,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              comp_hi,
   output logic                   sample_hold,
   output logic [WIDTH-1:0]       dac_code,
   output sac_analog_sel_t        analog_sel,
   output logic                   irq
);

   // ****************************************************************
   // address decode
   // ****************************************************************
   function automatic sac_reg_sel_t decode(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] idx;
      idx    = a >> 2;
      decode = sac_sel_none;
      if (a[1:0] == 2'h0) begin
         if (idx == ADDR_W'(`SAC_IDX_IRQ_EN)) begin
            decode = sac_sel_irq_en;
         end else if (idx == ADDR_W'(`SAC_IDX_IRQ_FLAG)) begin
            decode = sac_sel_irq_flag;
         end else if (idx == ADDR_W'(`SAC_IDX_RES_HI)) begin
            decode = sac_sel_res_hi;
         end else if (idx == ADDR_W'(`SAC_IDX_CTRL)) begin
            decode = sac_sel_ctrl;
         end else if (idx == ADDR_W'(`SAC_IDX_CFG)) begin
            decode = sac_sel_cfg;
         end
      end
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0]        w_byte;
   logic              w_lane0;
   logic              next_aw_held;
   logic              next_w_held;
   logic              next_bvalid;
   logic              next_rvalid;
   logic              aw_take;
   logic              w_take;
   logic              ar_take;
   logic              do_write;
   sac_reg_sel_t      wr_sel;
   sac_reg_sel_t      rd_sel;

   logic              conv_start_bit;
   logic              start_req;
   logic [2:0]        conv_clock_divider_select;
   logic [7:0]        conv_config;
   logic              conv_done_flag;
   logic              conv_done_irq_enable;
   logic [7:0]        div_cnt;
   logic [7:0]        div_limit;
   logic              tick;
   logic [WIDTH-1:0]  result;
   logic              core_done;
   logic              wr_ctrl;
   logic              wr_flag;
   logic              wr_en;
   logic              wr_cfg;
   logic [7:0]        rd_byte;

   logic [4:0]        input_channel_select;
   logic [1:0]        reference_select;
   logic              low_reference_select;

   assign input_channel_select = conv_config[`SAC_CHAN_MSB:`SAC_CHAN_LSB];
   assign reference_select     = conv_config[`SAC_REF_MSB:`SAC_REF_LSB];
   assign low_reference_select = conv_config[`SAC_LOWREF_BIT];

   // ****************************************************************
   // axi4-lite handshakes
   // ****************************************************************
   // one write and one read in flight; address and data may come in either order
   always_comb begin
      aw_take      = s_axi_awvalid && s_axi_awready;
      w_take       = s_axi_wvalid && s_axi_wready;
      ar_take      = s_axi_arvalid && s_axi_arready;
      do_write     = aw_held && w_held && !s_axi_bvalid;
      next_aw_held = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_held);
      next_w_held  = w_take ? 1'b1 : (do_write ? 1'b0 : w_held);
      next_bvalid  = do_write ? 1'b1 : ((s_axi_bvalid && s_axi_bready) ? 1'b0 : s_axi_bvalid);
      next_rvalid  = ar_take ? 1'b1 : ((s_axi_rvalid && s_axi_rready) ? 1'b0 : s_axi_rvalid);
      wr_sel       = decode(aw_addr);
      rd_sel       = decode(s_axi_araddr);
      wr_ctrl      = do_write && w_lane0 && (wr_sel == sac_sel_ctrl);
      wr_flag      = do_write && w_lane0 && (wr_sel == sac_sel_irq_flag);
      wr_en        = do_write && w_lane0 && (wr_sel == sac_sel_irq_en);
      wr_cfg       = do_write && w_lane0 && (wr_sel == sac_sel_cfg);
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_byte        <= 8'h00;
         w_lane0       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SAC_RESP_OKAY;
      end else begin
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         s_axi_bvalid  <= next_bvalid;
         // ready only reopens once the response has gone, so nothing queues up
         s_axi_awready <= !next_aw_held && !next_bvalid;
         s_axi_wready  <= !next_w_held && !next_bvalid;
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            s_axi_bresp <= (wr_sel == sac_sel_none) ? `SAC_RESP_SLVERR : `SAC_RESP_OKAY;
         end
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   always_comb begin
      rd_byte = 8'h00;
      unique case (rd_sel)
         sac_sel_irq_en:   rd_byte[`SAC_DONE_BIT] = conv_done_irq_enable;
         sac_sel_irq_flag: rd_byte[`SAC_DONE_BIT] = conv_done_flag;
         sac_sel_res_hi:   rd_byte = result[WIDTH-1:WIDTH-8];
         sac_sel_ctrl: begin
            rd_byte[`SAC_RESLO_MSB:`SAC_RESLO_LSB] = result[3:0];
            rd_byte[`SAC_START_BIT]                = conv_start_bit;
            rd_byte[`SAC_DIV_MSB:`SAC_DIV_LSB]     = conv_clock_divider_select;
         end
         sac_sel_cfg:      rd_byte = conv_config;
         sac_sel_none:     rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SAC_RESP_OKAY;
      end else begin
         s_axi_rvalid  <= next_rvalid;
         s_axi_arready <= !next_rvalid;
         if (ar_take) begin
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= (rd_sel == sac_sel_none) ? `SAC_RESP_SLVERR : `SAC_RESP_OKAY;
         end
      end
   end

   // ****************************************************************
   // control and configuration
   // ****************************************************************
   // a 1 written while busy is ignored, and a 0 never aborts a conversion
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         conv_start_bit            <= 1'b0;
         start_req                 <= 1'b0;
         conv_clock_divider_select <= `SAC_DIV_RESET;
      end else begin
         start_req <= 1'b0;
         if (wr_ctrl) begin
            conv_clock_divider_select <= w_byte[`SAC_DIV_MSB:`SAC_DIV_LSB];
         end
         if (core_done) begin
            conv_start_bit <= 1'b0;
         end else if (wr_ctrl && w_byte[`SAC_START_BIT] && !conv_start_bit) begin
            conv_start_bit <= 1'b1;
            start_req      <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         conv_config <= `SAC_CFG_RESET;
      end else if (wr_cfg) begin
         conv_config <= w_byte;
      end
   end

   // ****************************************************************
   // converter clock divider
   // ****************************************************************
   // divide ratio is 2^(8-select); one tick per converter clock period
   assign div_limit = `SAC_DIV_FULL >> conv_clock_divider_select;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt <= 8'h00;
         tick    <= 1'b0;
      end else if (start_req || div_cnt >= div_limit) begin
         // restart on start so the sample phase gets a whole period
         div_cnt <= 8'h00;
         tick    <= !start_req && (div_cnt >= div_limit);
      end else begin
         div_cnt <= div_cnt + 8'h01;
         tick    <= 1'b0;
      end
   end

   // ****************************************************************
   // approximation core
   // ****************************************************************
   // result is written by the core at the same edge its done pulse rises,
   // one edge before the start bit clears and the flag sets
   sac_sar_core #(
      .WIDTH (WIDTH)
   ) u_core (
      .mclk        (mclk),
      .arst_n      (arst_n),
      .tick        (tick),
      .start       (start_req),
      .comp_hi     (comp_hi),
      .sample_hold (sample_hold),
      .dac_code    (dac_code),
      .result      (result),
      .done        (core_done)
   );

   // ****************************************************************
   // interrupt flag and enable
   // ****************************************************************
   // a done event in the same cycle as a clearing write keeps the flag set
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         conv_done_flag <= 1'b0;
      end else begin
         conv_done_flag <= core_done
            || (conv_done_flag && !(wr_flag && !w_byte[`SAC_DONE_BIT]));
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         conv_done_irq_enable <= 1'b0;
      end else if (wr_en) begin
         conv_done_irq_enable <= w_byte[`SAC_DONE_BIT];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= conv_done_flag && conv_done_irq_enable;
      end
   end

   // ****************************************************************
   // analog selection outputs
   // ****************************************************************
   // reserved channel codes enable no input at all rather than a guess
   genvar ch;
   generate
      for (ch = 0; ch < `SAC_EXT_CHANNELS; ch++) begin : g_ext
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               analog_sel.ext_en[ch] <= 1'b0;
            end else begin
               analog_sel.ext_en[ch] <= (input_channel_select == 5'(ch));
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         analog_sel.bandgap_en <= 1'b0;
         analog_sel.quarter_en <= 1'b0;
         analog_sel.ref_src    <= sac_ref_supply;
      end else begin
         analog_sel.bandgap_en <= (input_channel_select == `SAC_CHAN_BANDGAP);
         analog_sel.quarter_en <= (input_channel_select == `SAC_CHAN_QUARTER);
         if (reference_select == `SAC_REF_LOW) begin
            analog_sel.ref_src <= low_reference_select ? sac_ref_bg_1p2 : sac_ref_supply;
         end else if (reference_select == `SAC_REF_2P48) begin
            analog_sel.ref_src <= sac_ref_bg_2p48;
         end else if (reference_select == `SAC_REF_2P00) begin
            analog_sel.ref_src <= sac_ref_bg_2p00;
         end else begin
            analog_sel.ref_src <= sac_ref_reserved;
         end
      end
   end

endmodule

/* logic/sac_consts.svh */
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define SAC_IDX_IRQ_EN   8'h0B
`define SAC_IDX_IRQ_FLAG 8'h0C
`define SAC_IDX_RES_HI   8'h17
`define SAC_IDX_CTRL     8'h18
`define SAC_IDX_CFG      8'h19

// ****************************************************************
// field positions
// ****************************************************************
`define SAC_DONE_BIT     7
`define SAC_START_BIT    3
`define SAC_DIV_MSB      2
`define SAC_DIV_LSB      0
`define SAC_RESLO_MSB    7
`define SAC_RESLO_LSB    4
`define SAC_REF_MSB      7
`define SAC_REF_LSB      6
`define SAC_LOWREF_BIT   5
`define SAC_CHAN_MSB     4
`define SAC_CHAN_LSB     0

// ****************************************************************
// reset values and codes
// ****************************************************************
`define SAC_CFG_RESET    8'h1F
`define SAC_DIV_RESET    3'h0
`define SAC_RESULT_RESET 12'h000
`define SAC_EXT_CHANNELS 13
`define SAC_CHAN_BANDGAP 5'h0E
`define SAC_CHAN_QUARTER 5'h17
`define SAC_REF_LOW      2'h0
`define SAC_REF_2P48     2'h1
`define SAC_REF_2P00     2'h3
`define SAC_DIV_FULL     8'hFF
`define SAC_RESP_OKAY    2'h0
`define SAC_RESP_SLVERR  2'h2

`endif

/* logic/sac_pkg.sv */
package sac_pkg;

   typedef enum logic [5:0] {
      sac_sel_none     = 6'h01,
      sac_sel_irq_en   = 6'h02,
      sac_sel_irq_flag = 6'h04,
      sac_sel_res_hi   = 6'h08,
      sac_sel_ctrl     = 6'h10,
      sac_sel_cfg      = 6'h20
   } sac_reg_sel_t;

   typedef enum logic [2:0] {
      sac_idle    = 3'h1,
      sac_sample  = 3'h2,
      sac_convert = 3'h4
   } sac_state_t;

   typedef enum logic [4:0] {
      sac_ref_supply   = 5'h01,
      sac_ref_bg_1p2   = 5'h02,
      sac_ref_bg_2p48  = 5'h04,
      sac_ref_bg_2p00  = 5'h08,
      sac_ref_reserved = 5'h10
   } sac_ref_t;

   typedef struct packed {
      logic [12:0] ext_en;
      logic        bandgap_en;
      logic        quarter_en;
      sac_ref_t    ref_src;
   } sac_analog_sel_t;

endpackage

/* logic/sac_sar_core.sv */
`include "sac_consts.svh"

module sac_sar_core
   import sac_pkg::*;
#(
   parameter int WIDTH = 12
) (
   input  wire logic             mclk,
   input  wire logic             arst_n,
   input  wire logic             tick,
   input  wire logic             start,
   input  wire logic             comp_hi,
   output logic                  sample_hold,
   output logic [WIDTH-1:0]      dac_code,
   output logic [WIDTH-1:0]      result,
   output logic                  done
);

   sac_state_t              state;
   logic [$clog2(WIDTH)-1:0] bit_idx;
   logic [WIDTH-1:0]         kept;

   // one converter clock to sample, then one bit decided per converter clock
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state       <= sac_idle;
         bit_idx     <= '0;
         kept        <= '0;
         dac_code    <= '0;
         sample_hold <= 1'b0;
         done        <= 1'b0;
         result      <= `SAC_RESULT_RESET;
      end else begin
         done <= 1'b0;
         unique case (state)
            sac_idle: begin
               if (start) begin
                  state       <= sac_sample;
                  sample_hold <= 1'b1;
               end
            end
            sac_sample: begin
               if (tick) begin
                  state       <= sac_convert;
                  sample_hold <= 1'b0;
                  bit_idx     <= ($clog2(WIDTH))'(WIDTH - 1);
                  kept        <= '0;
                  dac_code    <= WIDTH'(1) << (WIDTH - 1);
               end
            end
            sac_convert: begin
               if (tick) begin
                  // comparator high means input is at or above the trial code
                  if (bit_idx == '0) begin
                     result   <= comp_hi ? dac_code : kept;
                     done     <= 1'b1;
                     dac_code <= '0;
                     state    <= sac_idle;
                  end else begin
                     kept     <= comp_hi ? dac_code : kept;
                     dac_code <= (comp_hi ? dac_code : kept) | (WIDTH'(1) << (bit_idx - 1'b1));
                     bit_idx  <= bit_idx - 1'b1;
                  end
               end
            end
            default: state <= sac_idle;
         endcase
      end
   end

endmodule

/* test/sac_adc_ctrl_checker.sv */
// ************************************************
// bus and conversion checker
// ************************************************
module sac_adc_ctrl_checker
   import sac_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int WIDTH  = 12
) (
   input wire logic              mclk,
   input wire logic              arst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic [3:0]        s_axi_wstrb,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              comp_hi,
   input wire logic              sample_hold,
   input wire logic [WIDTH-1:0]  dac_code,
   input wire sac_analog_sel_t   analog_sel,
   input wire logic              irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   logic mapped;
   assign mapped = s_axi_awaddr inside {8'h2C, 8'h30, 8'h5C, 8'h60, 8'h64};

   // aw and w always offered together, so both are taken on one edge
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence zero_bit7(a);
      wr_taken ##0 (s_axi_awaddr == a && s_axi_wstrb[0] && !s_axi_wdata[7]);
   endsequence
   sequence conv_begin;
      $fell(sample_hold);
   endsequence

   chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_unmapped_err: assert property (wr_taken ##0 !mapped |-> ##2 s_axi_bresp == 2'h2)
      else $error("unmapped write not refused");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && s_axi_rdata[31:8] == 24'h0) else $error("read answer wrong");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");
   chk_flag_clear: assert property (zero_bit7(8'h30) |-> ##3 !irq)
      else $error("irq kept after flag clear");
   chk_mask_off: assert property (zero_bit7(8'h2C) |-> ##3 !irq)
      else $error("irq kept after mask");
   chk_sample_len: assert property ($rose(sample_hold) |-> ##[1:257] !sample_hold)
      else $error("sampling too long");
   chk_msb_first: assert property (conv_begin |-> ##[0:1] dac_code[WIDTH-1])
      else $error("first trial not msb");
endmodule

bind sac_adc_ctrl sac_adc_ctrl_checker #(.ADDR_W(ADDR_W), .WIDTH(WIDTH)) i_chk (
   .mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .comp_hi(comp_hi), .sample_hold(sample_hold),
   .dac_code(dac_code), .analog_sel(analog_sel), .irq(irq));

/* test/sar_adc_control_test.sv */
module sar_adc_control_test
   import sac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {
      logic [7:0]  cfg;
      logic [19:0] sel;
      logic [2:0]  div;
      logic [11:0] tgt;
      logic        en;
   } sac_row_t;

   localparam logic [7:0] A_EN = 8'h2C, A_FLAG = 8'h30, A_HI = 8'h5C;
   localparam logic [7:0] A_CTRL = 8'h60, A_CFG = 8'h64;

   logic            mclk = 1'b0, arst_n = 1'b0, comp_hi = 1'b0;
   logic            aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
   logic [7:0]      aw_a = 8'h00, ar_a = 8'h00;
   logic [31:0]     w_d = 32'h0, r_d, d;
   logic [3:0]      w_s = 4'h0;
   logic [1:0]      b_resp, r_resp, resp;
   logic            aw_rdy, w_rdy, b_v, ar_rdy, r_v, sample_hold, irq;
   logic [11:0]     dac_code, target = 12'h000, prev_code = 12'h000;
   sac_analog_sel_t analog_sel;
   int              num_errors = 0, compares = 0, cyc = 0, last_chg = 0, gap = 0;

   // config, expected selection, divider, analog level, irq enable
   sac_row_t rows [8] = '{
      '{8'h00, 20'h00081, 3'h0, 12'hA5C, 1'b1}, '{8'h2C, 20'h80002, 3'h1, 12'h000, 1'b0},
      '{8'h0E, 20'h00041, 3'h2, 12'hFFF, 1'b1}, '{8'hD7, 20'h00028, 3'h3, 12'h123, 1'b0},
      '{8'h8D, 20'h00010, 3'h4, 12'h800, 1'b1}, '{8'h45, 20'h01004, 3'h5, 12'h7FF, 1'b0},
      '{8'h1F, 20'h00001, 3'h6, 12'h5A5, 1'b1}, '{8'h6A, 20'h20004, 3'h7, 12'h001, 1'b1}};
   logic [7:0] rst_addr [5] = '{A_EN, A_FLAG, A_HI, A_CTRL, A_CFG};
   logic [7:0] rst_val [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h1F};

   sac_adc_ctrl i_dut (
      .mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
      .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v),
      .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
      .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
      .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
      .comp_hi(comp_hi), .sample_hold(sample_hold), .dac_code(dac_code),
      .analog_sel(analog_sel), .irq(irq));

   always #50 mclk = ~mclk;

   // ************************************************
   // comparator, tick spacing and watchdog
   // ************************************************
   // comparator lags the trial code one cycle; ticks are at least two cycles apart
   always @(posedge mclk) begin
      cyc++;
      comp_hi <= (target >= dac_code);
      if (dac_code !== prev_code) begin
         if (dac_code != 0 && prev_code != 0) gap = cyc - last_chg;
         last_chg = cyc;
      end
      prev_code = dac_code;
      if (cyc == 30000) begin
         num_errors++;
         stop_test();
      end
   end

   // ************************************************
   // bus tasks and compare
   // ************************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
      @(posedge mclk);
      aw_a <= a;
      w_d <= {24'h0, v};
      w_s <= s;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      do begin
         @(posedge mclk);
         if (aw_rdy) aw_v <= 1'b0;
         if (w_rdy) w_v <= 1'b0;
      end while (b_v !== 1'b1);
      resp = b_resp;
      b_r <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do begin
         @(posedge mclk);
         if (ar_rdy) ar_v <= 1'b0;
      end while (r_v !== 1'b1);
      d = r_d;
      resp = r_resp;
      r_r <= 1'b0;
   endtask

   task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      check(name, d, {24'h0, exp});
   endtask

   task automatic wait_done();
      do rd(A_CTRL); while (d[3] !== 1'b0);
   endtask

   // irq trails the flag register by one edge
   task automatic settle();
      repeat (2) @(posedge mclk);
   endtask

   task automatic stop_test();
      $display("num_errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      foreach (rows[i]) begin
         target = rows[i].tgt;
         wr(A_CFG, rows[i].cfg, 4'hF);
         rchk("config", A_CFG, rows[i].cfg);
         check("analog_sel", analog_sel, {12'h0, rows[i].sel});
         if (rows[i].cfg[6]) repeat (2000) @(posedge mclk);
         wr(A_EN, {rows[i].en, 7'h00}, 4'hF);
         wr(A_CTRL, {5'h01, rows[i].div}, 4'hF);
         rd(A_CTRL);
         check("busy", d[3], 1'b1);
         wait_done();
         check("tick_gap", gap, 1 << (8 - rows[i].div));
         check("result_low", d, {rows[i].tgt[3:0], 1'b0, rows[i].div});
         rchk("result_high", A_HI, rows[i].tgt[11:4]);
         rchk("flag_set", A_FLAG, 8'h80);
         settle();
         check("irq_en", irq, rows[i].en);
         wr(A_FLAG, 8'h7F, 4'hF);
         rchk("flag_clear", A_FLAG, 8'h00);
         settle();
         check("irq_clear", irq, 1'b0);
      end
      // a zero written to start while busy must not abort
      target = 12'h3C3;
      wr(A_EN, 8'h80, 4'hF);
      wr(A_CTRL, 8'h0C, 4'hF);
      wr(A_CTRL, 8'h04, 4'hF);
      rd(A_CTRL);
      check("no_abort", d[3], 1'b1);
      wait_done();
      rchk("result_keep", A_HI, 8'h3C);
      wr(A_FLAG, 8'hFF, 4'hF);
      rchk("flag_keep", A_FLAG, 8'h80);
      wr(A_EN, 8'h00, 4'hF);
      settle();
      check("irq_masked", irq, 1'b0);
      wr(A_EN, 8'h80, 4'hF);
      settle();
      check("irq_unmasked", irq, 1'b1);
      wr(A_FLAG, 8'h7F, 4'hF);
      // refused and ignored accesses
      wr(A_EN, 8'h00, 4'h0);
      check("strb_resp", resp, 2'h0);
      rchk("strb_ignored", A_EN, 8'h80);
      rd(8'h04);
      check("unmapped_rresp", resp, 2'h2);
      check("unmapped_rdata", d, 32'h0);
      wr(8'h61, 8'hFF, 4'hF);
      check("unaligned_bresp", resp, 2'h2);
      rchk("ctrl_untouched", A_CTRL, 8'h34);
      // reset in mid conversion
      wr(A_CTRL, 8'h08, 4'hF);
      repeat (20) @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      check("rst_irq", irq, 1'b0);
      check("rst_dac", dac_code, 12'h000);
      check("rst_sel", analog_sel, 32'h00001);
      arst_n <= 1'b1;
      @(posedge mclk);
      foreach (rst_addr[i]) rchk("reset_value", rst_addr[i], rst_val[i]);
      stop_test();
   end
endmodule
